// ### design/pce_map.vh
`ifndef PCE_MAP_VH
`define PCE_MAP_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define PCE_ADDR_DIG_MASK   8'h0B
`define PCE_ADDR_SPECIAL_FUNCTION_CONFIG     8'h0C
`define PCE_ADDR_ERR_CFG    8'h0D
`define PCE_ADDR_TEST_CAL   8'h0E
`define PCE_ADDR_CAL_TRIG   8'h2A
`define PCE_ADDR_TICK_CNT   8'h2E

// ----------------------------------------------------------------
// reset values and writable-bit masks
// ----------------------------------------------------------------
`define PCE_RST_DIG_MASK    8'h20
`define PCE_RST_SPECIAL_FUNCTION_CONFIG      8'h00
`define PCE_RST_ERR_CFG     8'h04
`define PCE_RST_TEST_CAL    8'h00
`define PCE_WMASK_DIG_MASK  8'h7F
`define PCE_WMASK_SPECIAL_FUNCTION_CONFIG    8'h3F
`define PCE_WMASK_ERR_CFG   8'h8F
`define PCE_WMASK_TEST_CAL  8'hFF
`define PCE_ZERO8           8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PCE_MSK_ROM         0
`define PCE_MSK_REGMAP      1
`define PCE_MSK_FREEZE      2
`define PCE_MSK_SCLK        3
`define PCE_SF_SWITCH_LO    0
`define PCE_SF_SWITCH_HI    1
`define PCE_SF_CALBUSY      2
`define PCE_SF_FAULT        3
`define PCE_SF_EXTCLK       4
`define PCE_SF_INTCLK       5
`define PCE_EC_DELAY_LO     0
`define PCE_EC_DELAY_HI     3
`define PCE_EC_NONLATCH     7
`define PCE_TC_MUX_LO       0
`define PCE_TC_MUX_HI       3
`define PCE_TC_SCHED_LO     4
`define PCE_TC_SCHED_HI     5
`define PCE_TC_CALTYPE      6
`define PCE_TC_GAIN_HI      7
`define PCE_TRIG_BIT        0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PCE_CLK_MHZ         40
`define PCE_TICK_US         1
`define PCE_MASTER_US       512
`define PCE_SCHED_S_1       9'd33
`define PCE_SCHED_S_2       9'd132
`define PCE_SCHED_S_3       9'd495
`define PCE_DLY_C9          7'd12
`define PCE_DLY_CA          7'd16
`define PCE_DLY_CB          7'd24
`define PCE_DLY_CC          7'd32
`define PCE_DLY_CD          7'd48
`define PCE_DLY_CE          7'd64
`define PCE_DLY_CF          7'd127

`endif

// ### design/pce_tick_div.v
`timescale 1ns/1ps
// divides a stream of step pulses by ratio, one tick per ratio steps
module pce_tick_div #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         step,
  input  wire [W-1:0] ratio,
  output reg          tick
);
  reg [W-1:0] cnt_reg;
  wire        wrap;

  // a ratio of zero behaves as one
  assign wrap = (cnt_reg >= ratio - {{(W-1){1'b0}}, 1'b1}) ||
                (ratio == {W{1'b0}});

  // step counter and registered tick
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= {W{1'b0}};
      tick    <= 1'b0;
    end else begin
      tick <= step & wrap;
      if (step) begin
        if (wrap) begin
          cnt_reg <= {W{1'b0}};
        end else begin
          cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // pce_tick_div

// ### design/pce_err_flag.v
`timescale 1ns/1ps
// one error flag: latching, or transparent after a persistence delay
module pce_err_flag (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       cond,
  input  wire       mask,
  input  wire       nonlatch,
  input  wire       tick,
  input  wire [6:0] delay,
  input  wire       clear,
  output reg        flag
);
  reg  [6:0] run_reg;
  wire       live;

  assign live = cond & ~mask;

  // persistence counter in microsecond ticks, saturating
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= 7'h00;
    end else if (!live) begin
      run_reg <= 7'h00;
    end else if (tick && run_reg != 7'h7F) begin
      run_reg <= run_reg + 7'h01;
    end
  end

  // flag update; in latching mode a new event wins over a clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (mask) begin
      flag <= 1'b0;
    end else if (nonlatch) begin
      flag <= live & (run_reg >= delay);
    end else if (live) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule // pce_err_flag

// ### design/pce_config.v
`timescale 1ns/1ps
`include "pce_map.vh"
// ----------------------------------------------------------------
// What this block does
// - freeze bit set stops the master tick counter, holding its value
// - serial clock count fault flag is forced off while its mask is set
// - register map checksum fault flag is forced off while masked
// - rom checksum fault flag is forced off while its mask is set
// - pin 4 output with clock-out enabled drives selected internal clock
// - pin 4 input with clock-import enabled makes it the timebase
// - imported clock is divided by the ext_clock_ratio input, zero acting as one
// - pin 3 output with fault enable shows the fault interrupt bit
// - pin 2 output with busy enable shows calibration busy
// - switch enable bits hand pins 1 and 0 to external switch bits
// - latching mode holds each tripped flag until it is cleared
// - non-latching mode shows error conditions transparently
// - non-latching flags set only after condition persists the delay
// - delay codes 0-8 literal, 9-F give 12,16,24,32,48,64,127
// - scale gain: 00 unity, lower bit 1.375, upper only 1.25
// - calibration type bit: 0 quick, 1 full
// - schedule field: off, or every 33, 132 or 495 seconds
// - during calibration inputs disconnect and busy stays asserted
// - test_input_and_cal_config code routes grounds or plus/minus 20 mV to inputs
// - test_input_and_cal_config reaches inputs only when both test switches are set
// - master tick counter advances every 512 us while not frozen
// - trigger write starts one calibration only when schedule is off
// ----------------------------------------------------------------
module pce_config #(
  parameter SECOND_US = 1000000,
  parameter CAL_QUICK_US = 100,
  parameter CAL_FULL_US = 1000
) (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       reg_wr_en,
  input  wire       reg_rd_en,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire [6:0] gpio_dir,
  input  wire [4:0] gpio_in,
  output reg  [4:0] gpio_out,
  output reg  [4:0] gpio_oe,
  input  wire       clock_out_select,
  input  wire [7:0] ext_clock_ratio,
  input  wire       fault_interrupt,
  input  wire [1:0] external_switch_bits,
  input  wire       scale_gain_lower_bit,
  input  wire       test_input_switch_a,
  input  wire       test_input_switch_b,
  input  wire       rom_checksum_fault_raw,
  input  wire       regmap_checksum_fault_raw,
  input  wire       serial_clock_count_fault_raw,
  input  wire [2:0] error_flag_clear,
  output wire [2:0] error_flags,
  output reg  [7:0] master_tick_counter,
  output reg  [1:0] scale_gain_code,
  output reg  [2:0] test_route_code,
  output reg        calibration_busy,
  output reg        calibration_full,
  output reg        inputs_disconnect,
  output reg        use_external_clock
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  localparam [15:0] QUICK_TICKS = CAL_QUICK_US / `PCE_TICK_US;
  localparam [15:0] FULL_TICKS  = CAL_FULL_US / `PCE_TICK_US;
  localparam [7:0]  INT_RATIO   = `PCE_CLK_MHZ * `PCE_TICK_US;
  localparam [9:0]  MASTER_TICKS = `PCE_MASTER_US / `PCE_TICK_US;
  localparam [19:0] SECOND_TICKS = SECOND_US / `PCE_TICK_US;
  localparam        ST_IDLE = 1'b0;
  localparam        ST_RUN  = 1'b1;

  reg rst_s1_reg;
  reg rst_n_reg;

  // two-stage release of the asynchronous reset
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  reg  [7:0] dig_mask_reg;
  reg  [7:0] special_function_config_reg;
  reg  [7:0] err_cfg_reg;
  reg  [7:0] test_cal_reg;
  wire [1:0] sched_sel;
  wire       trig_write;

  assign sched_sel = test_cal_reg[`PCE_TC_SCHED_HI:`PCE_TC_SCHED_LO];
  assign trig_write = reg_wr_en && (reg_addr == `PCE_ADDR_CAL_TRIG) &&
                      reg_wdata[`PCE_TRIG_BIT] && (sched_sel == 2'b00);

  // register writes, reserved bits stripped
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      dig_mask_reg <= `PCE_RST_DIG_MASK;
      special_function_config_reg   <= `PCE_RST_SPECIAL_FUNCTION_CONFIG;
      err_cfg_reg  <= `PCE_RST_ERR_CFG;
      test_cal_reg <= `PCE_RST_TEST_CAL;
    end else if (reg_wr_en) begin
      case (reg_addr)
        `PCE_ADDR_DIG_MASK:
          dig_mask_reg <= reg_wdata & `PCE_WMASK_DIG_MASK;
        `PCE_ADDR_SPECIAL_FUNCTION_CONFIG:
          special_function_config_reg <= reg_wdata & `PCE_WMASK_SPECIAL_FUNCTION_CONFIG;
        `PCE_ADDR_ERR_CFG:
          err_cfg_reg <= reg_wdata & `PCE_WMASK_ERR_CFG;
        `PCE_ADDR_TEST_CAL:
          test_cal_reg <= reg_wdata & `PCE_WMASK_TEST_CAL;
        default: begin
        end
      endcase
    end
  end

  // registered read data; unmapped and trigger read as zero
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      reg_rdata <= `PCE_ZERO8;
    end else if (reg_rd_en) begin
      case (reg_addr)
        `PCE_ADDR_DIG_MASK: reg_rdata <= dig_mask_reg;
        `PCE_ADDR_SPECIAL_FUNCTION_CONFIG:   reg_rdata <= special_function_config_reg;
        `PCE_ADDR_ERR_CFG:  reg_rdata <= err_cfg_reg;
        `PCE_ADDR_TEST_CAL: reg_rdata <= test_cal_reg;
        `PCE_ADDR_TICK_CNT: reg_rdata <= master_tick_counter;
        default:            reg_rdata <= `PCE_ZERO8;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // timebase: internal divider or imported clock on pin 4
  // ----------------------------------------------------------------
  reg  ext_s1_reg;
  reg  ext_s2_reg;
  reg  ext_s3_reg;
  reg  ext_lvl_reg;
  wire ext_rise;
  wire int_tick;
  wire ext_tick;
  wire us_tick;

  // three-stage sampler; a change counts once stages two and three agree
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ext_s1_reg  <= 1'b0;
      ext_s2_reg  <= 1'b0;
      ext_s3_reg  <= 1'b0;
      ext_lvl_reg <= 1'b0;
    end else begin
      ext_s1_reg <= gpio_in[4];
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      if (ext_s2_reg == ext_s3_reg) begin
        ext_lvl_reg <= ext_s3_reg;
      end
    end
  end

  assign ext_rise = (ext_s2_reg == ext_s3_reg) & ext_s3_reg & ~ext_lvl_reg;

  // timebase source selection
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      use_external_clock <= 1'b0;
    end else begin
      use_external_clock <= ~gpio_dir[4] &
                            special_function_config_reg[`PCE_SF_EXTCLK];
    end
  end

  pce_tick_div #(.W(8)) u_int_div (
    .clk   (clk),
    .rst_n (rst_n_reg),
    .step  (1'b1),
    .ratio (INT_RATIO),
    .tick  (int_tick)
  );

  // imported edges divided down to the microsecond tick
  pce_tick_div #(.W(8)) u_ext_div (
    .clk   (clk),
    .rst_n (rst_n_reg),
    .step  (ext_rise),
    .ratio (ext_clock_ratio),
    .tick  (ext_tick)
  );

  assign us_tick = use_external_clock ? ext_tick : int_tick;

  // ----------------------------------------------------------------
  // master tick counter
  // ----------------------------------------------------------------
  reg  [9:0] master_div_reg;
  wire       master_step;

  assign master_step = us_tick &&
                       (master_div_reg == MASTER_TICKS - 10'd1);

  // advances every 512 us unless frozen
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      master_div_reg      <= 10'd0;
      master_tick_counter <= `PCE_ZERO8;
    end else if (us_tick) begin
      if (master_step) begin
        master_div_reg <= 10'd0;
        if (!dig_mask_reg[`PCE_MSK_FREEZE]) begin
          master_tick_counter <= master_tick_counter + 8'h01;
        end
      end else begin
        master_div_reg <= master_div_reg + 10'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // error flags
  // ----------------------------------------------------------------
  reg  [6:0] delay_ticks;
  wire       nonlatch;

  assign nonlatch = err_cfg_reg[`PCE_EC_NONLATCH];

  // suppression code to microsecond count
  always @* begin
    case (err_cfg_reg[`PCE_EC_DELAY_HI:`PCE_EC_DELAY_LO])
      4'h9:    delay_ticks = `PCE_DLY_C9;
      4'hA:    delay_ticks = `PCE_DLY_CA;
      4'hB:    delay_ticks = `PCE_DLY_CB;
      4'hC:    delay_ticks = `PCE_DLY_CC;
      4'hD:    delay_ticks = `PCE_DLY_CD;
      4'hE:    delay_ticks = `PCE_DLY_CE;
      4'hF:    delay_ticks = `PCE_DLY_CF;
      default: delay_ticks = {3'b000,
                   err_cfg_reg[`PCE_EC_DELAY_HI:`PCE_EC_DELAY_LO]};
    endcase
  end

  pce_err_flag u_rom_flag (
    .clk      (clk),
    .rst_n    (rst_n_reg),
    .cond     (rom_checksum_fault_raw),
    .mask     (dig_mask_reg[`PCE_MSK_ROM]),
    .nonlatch (nonlatch),
    .tick     (us_tick),
    .delay    (delay_ticks),
    .clear    (error_flag_clear[0]),
    .flag     (error_flags[0])
  );

  pce_err_flag u_regmap_flag (
    .clk      (clk),
    .rst_n    (rst_n_reg),
    .cond     (regmap_checksum_fault_raw),
    .mask     (dig_mask_reg[`PCE_MSK_REGMAP]),
    .nonlatch (nonlatch),
    .tick     (us_tick),
    .delay    (delay_ticks),
    .clear    (error_flag_clear[1]),
    .flag     (error_flags[1])
  );

  pce_err_flag u_sclk_flag (
    .clk      (clk),
    .rst_n    (rst_n_reg),
    .cond     (serial_clock_count_fault_raw),
    .mask     (dig_mask_reg[`PCE_MSK_SCLK]),
    .nonlatch (nonlatch),
    .tick     (us_tick),
    .delay    (delay_ticks),
    .clear    (error_flag_clear[2]),
    .flag     (error_flags[2])
  );

  // ----------------------------------------------------------------
  // calibration scheduling and sequencing
  // ----------------------------------------------------------------
  reg  [19:0] sec_div_reg;
  reg  [8:0]  sec_cnt_reg;
  reg  [1:0]  sched_prev_reg;
  reg  [8:0]  sched_target;
  reg         cal_state_reg;
  reg  [15:0] cal_cnt_reg;
  wire        sec_step;
  wire        sched_due;

  // interval in seconds for each schedule code
  always @* begin
    case (sched_sel)
      2'b01:   sched_target = `PCE_SCHED_S_1;
      2'b10:   sched_target = `PCE_SCHED_S_2;
      2'b11:   sched_target = `PCE_SCHED_S_3;
      default: sched_target = 9'd0;
    endcase
  end

  assign sec_step  = us_tick && (sec_div_reg == SECOND_TICKS - 20'd1);
  assign sched_due = sec_step && (sched_sel != 2'b00) &&
                     (sec_cnt_reg >= sched_target - 9'd1);

  // second prescaler and interval counter, restarted on a new code
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sec_div_reg    <= 20'd0;
      sec_cnt_reg    <= 9'd0;
      sched_prev_reg <= 2'b00;
    end else begin
      sched_prev_reg <= sched_sel;
      if (sched_sel == 2'b00 || sched_sel != sched_prev_reg) begin
        sec_div_reg <= 20'd0;
        sec_cnt_reg <= 9'd0;
      end else if (us_tick) begin
        if (sec_step) begin
          sec_div_reg <= 20'd0;
          sec_cnt_reg <= sched_due ? 9'd0 : sec_cnt_reg + 9'd1;
        end else begin
          sec_div_reg <= sec_div_reg + 20'd1;
        end
      end
    end
  end

  // sequencer; a start while running is ignored
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cal_state_reg     <= ST_IDLE;
      cal_cnt_reg       <= 16'd0;
      calibration_busy  <= 1'b0;
      inputs_disconnect <= 1'b0;
      calibration_full  <= 1'b0;
    end else begin
      case (cal_state_reg)
        ST_IDLE: begin
          if (trig_write || sched_due) begin
            cal_state_reg     <= ST_RUN;
            cal_cnt_reg       <= 16'd0;
            calibration_busy  <= 1'b1;
            inputs_disconnect <= 1'b1;
            calibration_full  <= test_cal_reg[`PCE_TC_CALTYPE];
          end
        end
        ST_RUN: begin
          if (us_tick) begin
            if (cal_cnt_reg >= (calibration_full ? FULL_TICKS :
                                QUICK_TICKS) - 16'd1) begin
              cal_state_reg     <= ST_IDLE;
              calibration_busy  <= 1'b0;
              inputs_disconnect <= 1'b0;
            end else begin
              cal_cnt_reg <= cal_cnt_reg + 16'd1;
            end
          end
        end
        default: cal_state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // analog control decode
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      scale_gain_code <= 2'b00;
      test_route_code <= 3'd0;
    end else begin
      // 00 unity, 01 x1.375, 10 x1.25
      if (scale_gain_lower_bit) begin
        scale_gain_code <= 2'b01;
      end else if (test_cal_reg[`PCE_TC_GAIN_HI]) begin
        scale_gain_code <= 2'b10;
      end else begin
        scale_gain_code <= 2'b00;
      end
      // 0 open, 1 a/a, 2 d/a, 3 a/d, 4 d/d, 5 +20mV, 6 -20mV
      if (!(test_input_switch_a && test_input_switch_b)) begin
        test_route_code <= 3'd0;
      end else begin
        case (test_cal_reg[`PCE_TC_MUX_HI:`PCE_TC_MUX_LO])
          4'b0000: test_route_code <= 3'd1;
          4'b0001: test_route_code <= 3'd2;
          4'b0100: test_route_code <= 3'd3;
          4'b0101: test_route_code <= 3'd4;
          4'b1010: test_route_code <= 3'd5;
          4'b1111: test_route_code <= 3'd6;
          default: test_route_code <= 3'd0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // special functions on pins 0 to 4
  // ----------------------------------------------------------------
  reg clk_a_reg;
  reg clk_b_reg;

  // internal clocks: half the tick rate, and half the master rate
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      clk_a_reg <= 1'b0;
      clk_b_reg <= 1'b0;
    end else begin
      if (int_tick) begin
        clk_a_reg <= ~clk_a_reg;
      end
      if (master_step) begin
        clk_b_reg <= ~clk_b_reg;
      end
    end
  end

  // registered pin drive and enables
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      gpio_out <= 5'h00;
      gpio_oe  <= 5'h00;
    end else begin
      gpio_out[4] <= clock_out_select ? clk_b_reg : clk_a_reg;
      gpio_oe[4]  <= gpio_dir[4] & special_function_config_reg[`PCE_SF_INTCLK];
      gpio_out[3] <= fault_interrupt;
      gpio_oe[3]  <= gpio_dir[3] & special_function_config_reg[`PCE_SF_FAULT];
      gpio_out[2] <= calibration_busy;
      gpio_oe[2]  <= gpio_dir[2] & special_function_config_reg[`PCE_SF_CALBUSY];
      gpio_out[1] <= external_switch_bits[1];
      gpio_oe[1]  <= special_function_config_reg[`PCE_SF_SWITCH_HI];
      gpio_out[0] <= external_switch_bits[0];
      gpio_oe[0]  <= special_function_config_reg[`PCE_SF_SWITCH_LO];
    end
  end
endmodule // pce_config

// ### testbench/pce_config_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the config block
// ----------------------------------------
module pce_config_chk (
  input wire       clk,
  input wire       reset_n,
  input wire       reg_rd_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_rdata,
  input wire [6:0] gpio_dir,
  input wire [4:0] gpio_out,
  input wire [4:0] gpio_oe,
  input wire       fault_interrupt,
  input wire [1:0] external_switch_bits,
  input wire       test_input_switch_a,
  input wire       test_input_switch_b,
  input wire       rom_checksum_fault_raw,
  input wire [2:0] error_flags,
  input wire [7:0] master_tick_counter,
  input wire [2:0] test_route_code,
  input wire       calibration_busy,
  input wire       inputs_disconnect
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // read of the pin function register
  sequence s_rd_pin;
    reg_rd_en && reg_addr == 8'h0C;
  endsequence
  property p_rsvd;
    s_rd_pin |=> reg_rdata[7:6] == 2'b00;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits read nonzero");
  property p_disc;
    calibration_busy == inputs_disconnect;
  endproperty
  a_disc: assert property (p_disc)
    else $error("disconnect differs from busy");
  property p_open;
    !(test_input_switch_a && test_input_switch_b) |=> test_route_code == 3'h0;
  endproperty
  a_open: assert property (p_open)
    else $error("test route without both switches");
  property p_swpin;
    gpio_oe[0] |-> gpio_out[0] == $past(external_switch_bits[0]);
  endproperty
  a_swpin: assert property (p_swpin)
    else $error("pin 0 not following switch bit");
  property p_fault;
    gpio_oe[3] |-> $past(gpio_dir[3]) && gpio_out[3] == $past(fault_interrupt);
  endproperty
  a_fault: assert property (p_fault)
    else $error("pin 3 not showing fault");
  property p_busy;
    gpio_oe[2] |-> $past(gpio_dir[2]) &&
      gpio_out[2] == $past(calibration_busy);
  endproperty
  a_busy: assert property (p_busy)
    else $error("pin 2 not showing busy");
  property p_step;
    master_tick_counter != $past(master_tick_counter)
      |-> master_tick_counter == $past(master_tick_counter) + 8'h01;
  endproperty
  a_step: assert property (p_step)
    else $error("counter step not one");
  property p_cause;
    $rose(error_flags[0]) |-> $past(rom_checksum_fault_raw);
  endproperty
  a_cause: assert property (p_cause)
    else $error("flag set without condition");
endmodule // pce_config_chk

bind pce_config pce_config_chk i_pce_config_chk (.*);

// ### testbench/pce_ext_clk_src.sv
`timescale 1ns/1ps
// ----------------------------------------
// imported clock source for pin 4
// ----------------------------------------
module pce_ext_clk_src #(
  parameter real HALF_NS = 31.25
) (
  output logic clk_out
);
  // free-running half-duty clock, 16 MHz
  initial begin
    clk_out = 1'b0;
    forever #(HALF_NS) clk_out = ~clk_out;
  end
endmodule // pce_ext_clk_src

// ### testbench/tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// self-checking bench
// ----------------------------------------
module tb;
  logic       clk, reset_n, wr, rd, fint, sga, swa, swb, csel, prev;
  logic [7:0] addr, wdata, ratio;
  logic [6:0] dir;
  logic [1:0] xsw;
  logic [2:0] raw, clr;
  wire  [7:0] rdata, cnt;
  wire  [4:0] gout, goe;
  wire  [2:0] flags, route;
  wire  [1:0] gain;
  wire        busy, full, disc, ext, eclk;
  int         errors, n_compared, n, i;
  int         dly [16] = '{0,1,2,3,4,5,6,7,8,12,16,24,32,48,64,127};
  logic [7:0] rv [4] = '{8'h20, 8'h00, 8'h04, 8'h00};
  logic [7:0] wm [4] = '{8'h7F, 8'h3F, 8'h8F, 8'hFF};
  logic [7:0] tm [6] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h0A, 8'h0F};

  pce_ext_clk_src i_pce_ext_clk_src (.clk_out(eclk));
  pce_config #(.SECOND_US(10), .CAL_QUICK_US(4), .CAL_FULL_US(8))
  i_pce_config (.clk(clk), .reset_n(reset_n), .reg_wr_en(wr),
    .reg_rd_en(rd), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .gpio_dir(dir), .gpio_in({eclk, 4'h0}),
    .gpio_out(gout), .gpio_oe(goe), .clock_out_select(csel),
    .ext_clock_ratio(ratio), .fault_interrupt(fint),
    .external_switch_bits(xsw), .scale_gain_lower_bit(sga),
    .test_input_switch_a(swa), .test_input_switch_b(swb),
    .rom_checksum_fault_raw(raw[0]), .regmap_checksum_fault_raw(raw[1]),
    .serial_clock_count_fault_raw(raw[2]), .error_flag_clear(clr),
    .error_flags(flags), .master_tick_counter(cnt),
    .scale_gain_code(gain), .test_route_code(route),
    .calibration_busy(busy), .calibration_full(full),
    .inputs_disconnect(disc), .use_external_clock(ext));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {wr, addr, wdata} = {1'b1, a, d};
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    {rd, addr} = {1'b1, a};
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask
  // persistence delay of one suppression code
  task automatic dtest(input int c);
    wrr(8'h0D, 8'h80 | c[7:0]);
    cyc(5);
    raw[0] = 1'b1;
    if (dly[c] > 1) begin
      cyc(dly[c] * 40 - 45);
      chk({5'h0, flags}, 8'h00);
    end
    cyc(100);
    chk({5'h0, flags}, 8'h01);
    raw[0] = 1'b0;
    cyc(3);
    chk({5'h0, flags}, 8'h00);
  endtask
  // one triggered calibration and its length
  task automatic caltest(input logic [7:0] cf, input int us, input logic f);
    wrr(8'h0E, cf);
    wrr(8'h2A, 8'h01);
    chk({7'h0, busy}, 8'h01);
    chk({7'h0, full}, {7'h0, f});
    n = 0;
    while (busy === 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk(8'(n > (us - 1) * 40 && n <= us * 40 + 2), 8'h01);
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // watchdog
  initial begin
    #(100000 * 25);
    errors++;
    complete_run;
  end
  // test sequence
  initial begin
    {reset_n, wr, rd, fint, sga, swa, swb, csel, prev} = '0;
    {addr, wdata, dir, xsw, raw, clr, errors, n_compared} = '0;
    ratio = 8'h10;
    cyc(10);
    reset_n = 1'b1;
    cyc(4);
    for (i = 0; i < 4; i++) begin
      rdc(8'h0B + i[7:0], rv[i]);
      wrr(8'h0B + i[7:0], 8'hFF);
      rdc(8'h0B + i[7:0], wm[i]);
      wrr(8'h0B + i[7:0], 8'h00);
    end
    rdc(8'h40, 8'h00);
    rdc(8'h2A, 8'h00);
    $display("test registers done");
    raw = 3'h7;
    cyc(1);
    raw = 3'h0;
    cyc(3);
    chk({5'h0, flags}, 8'h07);
    clr = 3'h7;
    cyc(2);
    clr = 3'h0;
    cyc(2);
    chk({5'h0, flags}, 8'h00);
    wrr(8'h0B, 8'h0B);
    raw = 3'h7;
    cyc(5);
    chk({5'h0, flags}, 8'h00);
    raw = 3'h0;
    wrr(8'h0B, 8'h00);
    for (i = 0; i < 16; i++) dtest(i);
    wrr(8'h0D, 8'h00);
    $display("test flags done");
    {dir, xsw, fint} = {7'h7F, 2'b10, 1'b1};
    wrr(8'h0C, 8'h2F);
    cyc(3);
    chk({3'h0, goe}, 8'h1F);
    chk({4'h0, gout[3:0]}, 8'h0A);
    {dir, xsw, fint} = {7'h77, 2'b01, 1'b0};
    cyc(3);
    chk({4'h0, goe[3:0]}, 8'h07);
    chk({6'h0, gout[1:0]}, 8'h01);
    n = 0;
    prev = gout[4];
    repeat (400) begin
      @(negedge clk);
      n += int'(gout[4] !== prev);
      prev = gout[4];
    end
    chk(8'(n), 8'd10);
    dir = 7'h7F;
    wrr(8'h0C, 8'h04);
    $display("test pins done");
    caltest(8'h00, 4, 1'b0);
    caltest(8'h40, 8, 1'b1);
    wrr(8'h0E, 8'h10);
    wrr(8'h2A, 8'h01);
    chk({7'h0, busy}, 8'h00);
    n = 0;
    while (busy !== 1'b1 && n < 14000) begin
      @(negedge clk);
      n++;
    end
    chk(8'(n > 13100 && n < 13300), 8'h01);
    cyc(400);
    wrr(8'h0E, 8'h00);
    $display("test calibration done");
    {swa, swb} = 2'b11;
    for (i = 0; i < 6; i++) begin
      wrr(8'h0E, tm[i]);
      cyc(2);
      chk({5'h0, route}, 8'(i + 1));
    end
    swb = 1'b0;
    cyc(2);
    chk({5'h0, route}, 8'h00);
    wrr(8'h0E, 8'h80);
    cyc(2);
    chk({6'h0, gain}, 8'h02);
    sga = 1'b1;
    cyc(2);
    chk({6'h0, gain}, 8'h01);
    wrr(8'h0E, 8'h00);
    $display("test inputs done");
    csel = 1'b1;
    n = cnt;
    wait (cnt != n[7:0]);
    cyc(2);
    n = cnt;
    prev = gout[4];
    cyc(20400);
    chk(cnt, n[7:0]);
    chk({7'h0, gout[4]}, {7'h0, prev});
    cyc(200);
    chk(cnt, 8'(n + 1));
    chk({7'h0, gout[4]}, {7'h0, ~prev});
    wrr(8'h0B, 8'h04);
    n = cnt;
    cyc(21000);
    chk(cnt, n[7:0]);
    $display("test counter done");
    dir = 7'h6F;
    wrr(8'h0C, 8'h10);
    cyc(10);
    chk({7'h0, ext}, 8'h01);
    dir = 7'h7F;
    cyc(10);
    chk({7'h0, ext}, 8'h00);
    $display("test clock import done");
    complete_run;
  end
endmodule // tb
